// File: hdl/adc_seq_pkg.sv
// Shared constants, types and register map of the converter sequencer
package adc_seq_pkg;

  // APB address width and data width
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices as printed; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_IRQ_CONTROL = 12'h02c;
  localparam logic [ADDR_W-1:0] IDX_RESULT = 12'h0d0;
  localparam logic [ADDR_W-1:0] IDX_CONTROL = 12'h0e1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CONTROL = 12'(IDX_IRQ_CONTROL * 4);
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 12'(IDX_RESULT * 4);
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 12'(IDX_CONTROL * 4);

  // Event status and mask, byte addresses
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 12'h400;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = 12'h404;

  // Control register fields
  localparam int CH_LO = 0;
  localparam int RUN_BIT = 4;
  localparam int TM_LO = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h80;
  localparam logic [7:0] CONTROL_ONES = 8'h80;

  // Interrupt control register fields
  localparam int DONE_BIT = 1;
  localparam int IE_BIT = 3;
  localparam logic [7:0] IRQ_CONTROL_RESET = 8'hc0;
  localparam logic [7:0] IRQ_CONTROL_ONES = 8'hc0;

  // Event bits
  localparam int EV_W = 2;
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;

  // Conversion lengths in master clocks, indexed by the time field
  localparam int unsigned CONV_CLOCKS [4] = '{384, 256, 192, 128};
  // Each conversion is split into equal steps: sample steps, then one per bit
  localparam int unsigned CONV_STEPS = 16;
  localparam logic [3:0] SAMPLE_LAST = 4'h7;
  localparam int STEP_W = 5;

  // Step length for a time field value
  function automatic logic [STEP_W-1:0] step_of(input logic [1:0] sel);
    step_of = STEP_W'(CONV_CLOCKS[sel] / CONV_STEPS);
  endfunction

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_sample = 2'b01,
    st_trial = 2'b10
  } state_type;

  // Drive toward the analog multiplexer and comparator
  typedef struct packed {
    logic [1:0] channel;
    logic sample;
    logic [7:0] trial;
  } analog_drive_type;

endpackage

// File: hdl/adc_sequencer_control.sv
// Sequencer, register file and interrupt logic of the 8-bit converter
//
// Behaviour
// - One of four inputs is converted per run and yields an 8-bit result.
// - Control bits 1:0 pick input 0 to 3 by their binary value.
// - The channel is latched at start and field changes during a run are ignored.
// - Writing one to control bit 4 starts a run, and the bit reads one while busy.
// - Writing zero to control bit 4 during a run stops it.
// - The run bit clears itself when a conversion completes.
// - Control bits 6:5 give 384, 256, 192 or 128 clocks per conversion.
// - A length change during a run applies only to later runs.
// - At completion the result goes into the read-only result register.
// - The done flag, bit 1, is set at completion and is cleared by a software zero or by any reset source.
// - Interrupt control bit 3 enables the completion request.
// - Control resets to 80H, bit 7 reads one and bits 3:2 read zero.
// - Every reset source returns interrupt control to C0H.
// - The result register has no defined reset value.
module adc_sequencer_control
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic break_reset,
  input wire logic trap_reset,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_high,
  output analog_drive_type analog,
  output logic irq_request,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic soft_reset;
  logic commit;
  logic wr;
  logic hit_control;
  logic hit_irq_control;
  logic hit_status;
  logic hit_mask;
  logic [DATA_W-1:0] next_prdata;
  logic next_pslverr;
  logic [7:0] control_read;
  logic [7:0] irq_control_read;

  logic [1:0] channel_select;
  logic [1:0] conv_time_sel;
  logic conversion_run;
  logic conversion_done_flag;
  logic done_irq_enable;
  logic [7:0] adc_result;
  logic [EV_W-1:0] event_status;
  logic [EV_W-1:0] event_mask;

  logic [2:0] comp_sync;
  logic comp_level;

  state_type state;
  logic [STEP_W-1:0] step_cnt;
  logic [STEP_W-1:0] step_len;
  logic [3:0] phase;
  logic [7:0] trial_bit;
  logic [7:0] next_code;
  logic step_end;
  logic start;
  logic abort;
  logic finish;

  ////////////////////////////////////////////////////////////////////////
  // Reset sources

  // Break and opcode trap act as synchronous resets of the register state
  assign soft_reset = break_reset | trap_reset;

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  // Access phase completes on the second cycle, when pready is high
  assign commit = psel & penable & pready;
  assign wr = commit & pwrite;

  // Address decode
  always_comb begin
    hit_control = 1'b0;
    hit_irq_control = 1'b0;
    hit_status = 1'b0;
    hit_mask = 1'b0;
    if (paddr == ADDR_CONTROL) begin
      hit_control = 1'b1;
    end else if (paddr == ADDR_IRQ_CONTROL) begin
      hit_irq_control = 1'b1;
    end else if (paddr == ADDR_EVENT_STATUS) begin
      hit_status = 1'b1;
    end else if (paddr == ADDR_EVENT_MASK) begin
      hit_mask = 1'b1;
    end
  end

  // Read images: unprovided bits read one, reserved bits read zero
  always_comb begin
    control_read = CONTROL_ONES;
    control_read[CH_LO +: 2] = channel_select;
    control_read[RUN_BIT] = conversion_run;
    control_read[TM_LO +: 2] = conv_time_sel;
    irq_control_read = IRQ_CONTROL_ONES;
    irq_control_read[DONE_BIT] = conversion_done_flag;
    irq_control_read[IE_BIT] = done_irq_enable;
  end

  // Read mux; an unmapped address reads zero and answers an error
  always_comb begin
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (paddr == ADDR_CONTROL) begin
      next_prdata = {24'h00_0000, control_read};
    end else if (paddr == ADDR_IRQ_CONTROL) begin
      next_prdata = {24'h00_0000, irq_control_read};
    end else if (paddr == ADDR_RESULT) begin
      next_prdata = {24'h00_0000, adc_result};
    end else if (paddr == ADDR_EVENT_STATUS) begin
      next_prdata = {30'h0000_0000, event_status};
    end else if (paddr == ADDR_EVENT_MASK) begin
      next_prdata = {30'h0000_0000, event_mask};
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // Answer flops; one wait state keeps every bus output registered
  // Trade-off: each access costs a cycle, but no bus output is combinational
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= next_pslverr;
      prdata <= pwrite ? '0 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register

  // Channel and time fields may be written any time; the run latches them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_select <= CONTROL_RESET[CH_LO +: 2];
      conv_time_sel <= CONTROL_RESET[TM_LO +: 2];
    end else if (soft_reset) begin
      channel_select <= CONTROL_RESET[CH_LO +: 2];
      conv_time_sel <= CONTROL_RESET[TM_LO +: 2];
    end else if (wr && hit_control) begin
      channel_select <= pwdata[CH_LO +: 2];
      conv_time_sel <= pwdata[TM_LO +: 2];
    end
  end

  // Run bit: completion wins over a software write in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conversion_run <= CONTROL_RESET[RUN_BIT];
    end else if (soft_reset) begin
      conversion_run <= CONTROL_RESET[RUN_BIT];
    end else if (finish) begin
      conversion_run <= 1'b0;
    end else if (wr && hit_control) begin
      conversion_run <= pwdata[RUN_BIT];
    end
  end

  // Start only from idle; a repeated one while busy keeps the run going
  // Such a write neither restarts nor lengthens the run in progress
  assign start = wr && hit_control && pwdata[RUN_BIT] && !conversion_run && !finish;
  assign abort = wr && hit_control && !pwdata[RUN_BIT] && conversion_run && !finish;

  ////////////////////////////////////////////////////////////////////////
  // Comparator input synchroniser

  // Three flops; the level moves only when the last two agree
  // The filtered level trails the pin by four cycles, so the shortest step
  // of eight clocks still leaves the comparator time to settle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comp_sync <= 3'h0;
    end else begin
      comp_sync <= {comp_sync[1:0], comparator_high};
    end
  end

  // Filtered comparator level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comp_level <= 1'b0;
    end else if (comp_sync[1] == comp_sync[2]) begin
      comp_level <= comp_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Successive approximation sequencer

  // Sixteen equal steps: eight for sampling, then one per result bit
  assign step_end = (step_cnt == STEP_W'(step_len - 5'h1));
  assign finish = (state == st_trial) && step_end && trial_bit[0];

  // Keep the trial bit if the input is at or above the trial level
  always_comb begin
    next_code = analog.trial;
    if (!comp_level) begin
      next_code = analog.trial & ~trial_bit;
    end
    next_code = next_code | (trial_bit >> 1);
  end

  // Step timing and phase; the length is fixed when the run starts
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      step_cnt <= '0;
      step_len <= '0;
      phase <= 4'h0;
      trial_bit <= 8'h00;
    end else if (soft_reset || abort) begin
      state <= st_idle;
      step_cnt <= '0;
      phase <= 4'h0;
      trial_bit <= 8'h00;
    end else if (start) begin
      state <= st_sample;
      step_cnt <= '0;
      step_len <= step_of(pwdata[TM_LO +: 2]);
      phase <= 4'h0;
      trial_bit <= 8'h00;
    end else if (state != st_idle) begin
      if (step_end) begin
        step_cnt <= '0;
        phase <= 4'(phase + 4'h1);
        if (state == st_sample && phase == SAMPLE_LAST) begin
          state <= st_trial;
          trial_bit <= 8'h80;
        end else if (state == st_trial) begin
          trial_bit <= trial_bit >> 1;
          if (trial_bit[0]) begin
            state <= st_idle;
          end
        end
      end else begin
        step_cnt <= STEP_W'(step_cnt + 5'h1);
      end
    end
  end

  // Analog drive: channel latched at start, sample window, trial code
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      analog <= '0;
    end else if (soft_reset || abort) begin
      analog.sample <= 1'b0;
      analog.trial <= 8'h00;
    end else if (start) begin
      analog.channel <= pwdata[CH_LO +: 2];
      analog.sample <= 1'b1;
      analog.trial <= 8'h00;
    end else if (step_end && state == st_sample && phase == SAMPLE_LAST) begin
      analog.sample <= 1'b0;
      analog.trial <= 8'h80;
    end else if (step_end && state == st_trial) begin
      analog.trial <= next_code;
    end
  end

  // Result register; deliberately left without a reset value
  // Read it only after the run bit clears; a stopped run leaves the old value
  always_ff @(posedge clk) begin
    if (finish) begin
      adc_result <= next_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt control register

  // Done flag: set wins over a software clear; writing one has no effect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conversion_done_flag <= IRQ_CONTROL_RESET[DONE_BIT];
    end else if (soft_reset) begin
      conversion_done_flag <= IRQ_CONTROL_RESET[DONE_BIT];
    end else if (finish) begin
      conversion_done_flag <= 1'b1;
    end else if (wr && hit_irq_control && !pwdata[DONE_BIT]) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // Completion interrupt enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_irq_enable <= IRQ_CONTROL_RESET[IE_BIT];
    end else if (soft_reset) begin
      done_irq_enable <= IRQ_CONTROL_RESET[IE_BIT];
    end else if (wr && hit_irq_control) begin
      done_irq_enable <= pwdata[IE_BIT];
    end
  end

  // Request toward the interrupt controller, one cycle behind the flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= conversion_done_flag & done_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status, mask and level interrupt

  // Sticky events, cleared by writing one; a new event wins over the clear
  // The abort event lets software tell a stopped run from a finished one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_status <= '0;
    end else if (soft_reset) begin
      event_status <= '0;
    end else begin
      for (int i = 0; i < EV_W; i++) begin
        if ((i == EV_DONE && finish) || (i == EV_ABORT && abort)) begin
          event_status[i] <= 1'b1;
        end else if (wr && hit_status && pwdata[i]) begin
          event_status[i] <= 1'b0;
        end
      end
    end
  end

  // Mask, same layout as the status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_mask <= '0;
    end else if (soft_reset) begin
      event_mask <= '0;
    end else if (wr && hit_mask) begin
      event_mask <= pwdata[EV_W-1:0];
    end
  end

  // Level interrupt, registered so the output comes from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

endmodule // adc_sequencer_control

// File: verif/adc_analog_model.sv
// Behavioural analog multiplexer, sample-and-hold and comparator
module adc_analog_model
  import adc_seq_pkg::*;
#(
  parameter logic [31:0] LEVELS = 32'hfe01_c35a
)
(
  input wire logic clk,
  input wire analog_drive_type analog,
  output logic comparator_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held;

  ////////////////////////////////////////////////////////////////////////////////
  // Hold the chosen input while the window is open, so a later mux change is moot
  always_ff @(posedge clk) begin
    if (analog.sample) begin
      held <= LEVELS[analog.channel*8 +: 8];
    end
  end

  // Registered compare: a slow comparator, one cycle late on every trial
  always_ff @(posedge clk) begin
    comparator_high <= (held >= analog.trial);
  end
endmodule // adc_analog_model

// File: verif/adc_sequencer_control_chk.sv
// Port-level checker of the converter sequencer
module adc_seq_chk
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic break_reset,
  input wire logic trap_reset,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire analog_drive_type analog,
  input wire logic irq_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] samp_cnt;
  wire rd_ack = pready && psel && !pwrite && !pslverr;
  wire wr_ctl = psel && penable && pready && pwrite && paddr == ADDR_CONTROL;
  wire wr_irq = psel && pwrite && paddr == ADDR_IRQ_CONTROL;
  wire srst = break_reset || trap_reset;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // Length of the open sample window; aborts are excluded below
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      samp_cnt <= 8'h00;
    end else begin
      samp_cnt <= analog.sample ? samp_cnt + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  start_chan_a: assert property ($rose(analog.sample) |-> $past(wr_ctl && pwdata[4]) &&
    analog.channel == $past(pwdata[1:0])) else $error("start without run write");
  chan_hold_a: assert property (analog.sample && $past(analog.sample) |->
    $stable(analog.channel)) else $error("channel moved in a run");
  abort_stop_a: assert property (analog.sample && wr_ctl && !pwdata[4] |=>
    !analog.sample) else $error("abort did not stop");
  sample_len_a: assert property ($fell(analog.sample) && analog.trial == 8'h80 &&
    !$past(wr_ctl) |-> samp_cnt inside {8'd64, 8'd96, 8'd128, 8'd192})
    else $error("sample window length wrong");
  ctl_read_a: assert property (rd_ack && paddr == ADDR_CONTROL |->
    prdata[7] && prdata[3:2] == 2'h0) else $error("control fixed bits wrong");
  irqc_read_a: assert property (rd_ack && paddr == ADDR_IRQ_CONTROL |->
    prdata[7:6] == 2'h3 && prdata[5:4] == 2'h0) else $error("irq control fixed bits");
  irq_match_a: assert property (rd_ack && paddr == ADDR_IRQ_CONTROL |->
    irq_request == (prdata[1] && prdata[3])) else $error("request disagrees");
  done_sticky_a: assert property (irq_request && !$past(wr_irq) && !$past(srst) |=>
    irq_request) else $error("request dropped by itself");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
endmodule // adc_seq_chk

bind adc_sequencer_control adc_seq_chk u_chk (
  .clk(clk), .nrst(nrst), .break_reset(break_reset), .trap_reset(trap_reset),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog(analog),
  .irq_request(irq_request)
);

// File: verif/adc_sequencer_control_test.sv
// Self-checking testbench of the converter sequencer
module adc_sequencer_control_test
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] LEVELS = 32'hfe01_c35a;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic break_reset = 1'b0;
  logic trap_reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic comparator_high;
  analog_drive_type analog;
  logic irq_request;
  logic irq;
  int num_errors = 0;
  int checked = 0;
  time t_edge;
  logic [31:0] q;
  logic err;

  always #2.5 clk = ~clk;

  adc_sequencer_control u_dut (.clk(clk), .nrst(nrst), .break_reset(break_reset),
    .trap_reset(trap_reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_high(comparator_high), .analog(analog),
    .irq_request(irq_request), .irq(irq));
  adc_analog_model #(.LEVELS(LEVELS)) u_model (.clk(clk), .analog(analog),
    .comparator_high(comparator_high));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycle and waits
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; an idle edge follows so psel never toggles in one step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) num_errors++;
    q = prdata;
    err = pslverr;
    t_edge = $time;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 500);
    // A completion that never comes is a mismatch, not a silent pass
    if (irq !== 1'b1) num_errors++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, an unmapped read, and the event mask opened
  task automatic t_reset();
    rd(ADDR_CONTROL, 32'h80);
    rd(ADDR_IRQ_CONTROL, 32'hc0);
    rd(ADDR_EVENT_STATUS, 32'h0);
    rd(12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_EVENT_MASK, 32'h3);
  endtask

  // Every channel and length; fields rewritten mid-run must not matter
  task automatic t_conv();
    logic [1:0] s;
    time t0;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      apb(1'b1, ADDR_IRQ_CONTROL, {28'h0, s[0], 3'h0});
      apb(1'b1, ADDR_CONTROL, {25'h0, s, 3'h4, s});
      t0 = t_edge;
      apb(1'b1, ADDR_CONTROL, {25'h0, ~s, 3'h4, ~s});
      wait_irq();
      chk(32'(($time - t0) / 5), 32'(CONV_CLOCKS[i] + 2));
      rd(ADDR_CONTROL, {24'h0, 1'b1, ~s, 3'h0, ~s});
      rd(ADDR_RESULT, {24'h0, LEVELS[i*8 +: 8]});
      rd(ADDR_IRQ_CONTROL, {24'h0, 4'hc, s[0], 3'h2});
      chk({31'h0, irq_request}, {31'h0, s[0]});
      apb(1'b1, ADDR_EVENT_STATUS, 32'h1);
      apb(1'b1, ADDR_IRQ_CONTROL, 32'h0);
      rd(ADDR_IRQ_CONTROL, 32'hc0);
      chk({30'h0, irq_request, irq}, 32'h0);
    end
  endtask

  // Stop a long run early: no done flag, no result event, ever
  task automatic t_abort();
    apb(1'b1, ADDR_CONTROL, 32'h11);
    repeat (20) @(posedge clk);
    apb(1'b1, ADDR_CONTROL, 32'h01);
    wait_irq();
    rd(ADDR_EVENT_STATUS, 32'h2);
    rd(ADDR_CONTROL, 32'h81);
    repeat (400) @(posedge clk);
    rd(ADDR_IRQ_CONTROL, 32'hc0);
    apb(1'b1, ADDR_EVENT_STATUS, 32'h2);
    rd(ADDR_EVENT_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  // Break and trap resets each restore both control registers
  task automatic t_sync();
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CONTROL, 32'h63);
      apb(1'b1, ADDR_IRQ_CONTROL, 32'h08);
      rd(ADDR_CONTROL, 32'he3);
      rd(ADDR_IRQ_CONTROL, 32'hc8);
      break_reset <= (k == 0);
      trap_reset <= (k == 1);
      @(posedge clk);
      break_reset <= 1'b0;
      trap_reset <= 1'b0;
      @(posedge clk);
      rd(ADDR_CONTROL, 32'h80);
      rd(ADDR_IRQ_CONTROL, 32'hc0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_conv();
    t_abort();
    t_sync();
    print_verdict();
  end

  // Watchdog: the whole run needs well under a fifth of this span
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule // adc_sequencer_control_test
